// ===== core/pma_mgmt_pkg.sv
package pma_mgmt_pkg;
	localparam logic [4:0] DEV_MEDIUM = 5'h01;
	localparam logic [4:0] DEV_VENDOR = 5'h1F;
	localparam logic [15:0] OFS_CTRL1 = 16'h0000;
	localparam logic [15:0] OFS_STAT1 = 16'h0001;
	localparam logic [15:0] OFS_DEVS_LO = 16'h0005;
	localparam logic [15:0] OFS_DEVS_HI = 16'h0006;
	localparam logic [15:0] OFS_GEN_CNT_HI = 16'h8027;
	localparam logic [15:0] OFS_GEN_CNT_LO = 16'h8028;
	localparam logic [15:0] OFS_GEN_FIN = 16'h8029;
	localparam logic [15:0] OFS_HOST_LB = 16'h8055;
	localparam logic [15:0] OFS_PKT_BEGIN = 16'h805A;
	localparam logic [15:0] RST_CTRL1 = 16'h0000;
	localparam logic [15:0] RST_GEN_CNT_HI = 16'h0000;
	localparam logic [15:0] RST_GEN_CNT_LO = 16'h0100;
	localparam logic [15:0] RST_GEN_FIN = 16'h0000;
	localparam logic [15:0] RST_HOST_LB = 16'h000A;
	localparam logic [15:0] RST_PKT_BEGIN = 16'h001B;
	localparam logic [15:0] DEVS_LO_VAL = 16'h008B;
	localparam logic [15:0] DEVS_HI_VAL = 16'hC000;
	localparam int BIT_SOFT_RESET = 15;
	localparam int BIT_POWERDOWN = 11;
	localparam int BIT_LOCAL_LB = 0;
	localparam int BIT_LINK_LL = 2;
	localparam int BIT_PD_ABLE = 1;
	localparam int BIT_GEN_FIN = 0;
	localparam logic [1:0] OP_ADDRESS = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ_INC = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	localparam logic [5:0] PREAMBLE_BITS = 6'h20;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SOFT_RST_TIME_NS = 128;
	localparam logic [7:0] SOFT_RST_CYCLES =
		8'((SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ===== core/mdio_frame_engine.sv
module mdio_frame_engine
	import pma_mgmt_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n,
	input wire logic [4:0] phy_addr,
	output logic wr_pulse,
	output logic rd_pulse,
	output logic [4:0] acc_dev,
	output logic [15:0] acc_addr,
	output logic [15:0] wr_data,
	input wire logic [15:0] rd_data
);
	typedef enum logic [1:0] {S_PRE, S_HDR, S_TA, S_DATA} mdio_state_t;

	mdio_state_t state_r;
	logic mdc_q_r;
	logic [5:0] ones_r;
	logic [3:0] cnt_r;
	logic [15:0] sh_r;
	logic [1:0] op_r;
	logic [15:0] addr_med_r;
	logic [15:0] addr_vnd_r;
	wire mdc_rise = mdc & ~mdc_q_r;
	wire [13:0] hdr = {sh_r[12:0], mdio_i};
	wire [15:0] word_in = {sh_r[14:0], mdio_i};
	wire is_read = op_r[1];
	// Frames for any other MMD are left alone so other devices on the bus can answer.
	wire hdr_ok = (hdr[13:12] == 2'h0) && (hdr[9:5] == phy_addr)
		&& ((hdr[4:0] == DEV_MEDIUM) || (hdr[4:0] == DEV_VENDOR)); // see RQ12
	wire last_bit = (cnt_r == 4'hF);

	assign acc_addr = (acc_dev == DEV_MEDIUM) ? addr_med_r : addr_vnd_r;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= S_PRE;
			mdc_q_r <= 1'b0;
			ones_r <= 6'h0;
			cnt_r <= 4'h0;
			sh_r <= 16'h0000;
			op_r <= 2'h0;
			acc_dev <= 5'h0;
			mdio_o <= 1'b1;
			mdio_oe_n <= 1'b1;
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			wr_data <= 16'h0000;
			addr_med_r <= 16'h0000;
			addr_vnd_r <= 16'h0000;
		end
		else
		begin
			mdc_q_r <= mdc;
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			if (mdc_rise)
			begin
				unique case (state_r)
					S_PRE:
					begin
						if (mdio_i)
							ones_r <= (ones_r == PREAMBLE_BITS) ? ones_r : ones_r + 6'h1;
						else
						begin
							ones_r <= 6'h0;
							if (ones_r == PREAMBLE_BITS)
							begin
								state_r <= S_HDR;
								cnt_r <= 4'h1;
								sh_r <= 16'h0000;
							end
						end
					end
					S_HDR:
					begin
						sh_r <= word_in;
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'hD)
						begin
							state_r <= hdr_ok ? S_TA : S_PRE;
							op_r <= hdr[11:10];
							acc_dev <= hdr[4:0];
							cnt_r <= 4'h0;
						end
					end
					S_TA:
					begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'h0)
						begin
							mdio_o <= 1'b0;
							mdio_oe_n <= ~is_read;
						end
						else
						begin
							state_r <= S_DATA;
							cnt_r <= 4'h0;
							if (is_read)
							begin
								mdio_o <= rd_data[15];
								sh_r <= {rd_data[14:0], 1'b0};
								rd_pulse <= 1'b1;
							end
						end
					end
					S_DATA:
					begin
						cnt_r <= cnt_r + 4'h1;
						if (is_read)
						begin
							mdio_o <= last_bit ? 1'b1 : sh_r[15];
							sh_r <= {sh_r[14:0], 1'b0};
						end
						else
							sh_r <= word_in;
						if (last_bit)
						begin
							state_r <= S_PRE;
							mdio_oe_n <= 1'b1;
							if (op_r == OP_WRITE)
							begin
								wr_pulse <= 1'b1;
								wr_data <= word_in;
							end
							if (op_r == OP_ADDRESS || op_r == OP_READ_INC)
							begin
								if (acc_dev == DEV_MEDIUM)
									addr_med_r <= (op_r == OP_ADDRESS) ? word_in
										: addr_med_r + 16'h0001;
								else
									addr_vnd_r <= (op_r == OP_ADDRESS) ? word_in
										: addr_vnd_r + 16'h0001;
							end
						end
					end
				endcase
			end
		end
	end
endmodule // mdio_frame_engine

// ===== core/pma_pmd_mgmt_register_bank.sv
// Operation
// RQ1 - Writing control bit 15 starts a whole-bank reinitialisation like hardware reset.
// RQ2 - Soft reset bit clears itself; reads 1 only while reset runs.
// RQ3 - Control bit 11 puts the chip into low-power mode.
// RQ4 - Management reads and writes keep working during power-down.
// RQ5 - Power-down reset value comes from the strap pin.
// RQ6 - Control register resets to 0x0000 apart from strap-driven bits.
// RQ7 - Control bit 0 loops transmit data back to receive; 0 is normal.
// RQ8 - Status bit 2 reads 1 when up, 0 if link dropped since last read.
// RQ9 - Status bit 1 always reads 1: power-down supported.
// RQ10 - First devices-in-package word reads constant 0x8B.
// RQ11 - Second devices-in-package word reads constant 0xC000.
// RQ12 - Medium registers answer at device address 0x01 only.
// RQ13 - Frame count low half at 0x8028, read-write, reset 0x0100.
// RQ14 - Generator finished flag at 0x8029, read-only, reset 0x0000.
// RQ15 - Host-side loopback setup at 0x8055, read-write, reset 0x000A.
// RQ16 - Packet start generation setup at 0x805A, read-write, reset 0x001B.
// RQ17 - Frame count high half at 0x8027, read-write, reset 0x0000.
// RQ18 - Reserved control and status bits read zero, ignore writes.
// RQ19 - Reading a latched zero re-arms the link latch to current state.
module pma_pmd_mgmt_register_bank (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n,
	input wire logic [4:0] phy_addr,
	input wire logic powerdown_strap_pin,
	input wire logic link_up,
	input wire logic gen_run_done,
	output logic chip_soft_reset,
	output logic medium_soft_powerdown,
	output logic medium_local_loopback_en,
	output logic [15:0] gen_frame_count_high,
	output logic [15:0] gen_frame_count_low,
	output logic [15:0] host_side_loopback_cfg,
	output logic [15:0] packet_begin_generation_cfg
);
	import pma_mgmt_pkg::*;

	function automatic logic hit(input logic [4:0] dev, input logic [15:0] addr,
		input logic [4:0] want_dev, input logic [15:0] want_addr);
		hit = (dev == want_dev) && (addr == want_addr);
	endfunction

	logic wr_pulse;
	logic rd_pulse;
	logic [4:0] acc_dev;
	logic [15:0] acc_addr;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic [7:0] srst_cnt_r;
	logic init_done_r;
	logic link_ll_r;
	logic gen_fin_r;

	mdio_frame_engine u_mdio (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.mdc(mdc),
		.mdio_i(mdio_i),
		.mdio_o(mdio_o),
		.mdio_oe_n(mdio_oe_n),
		.phy_addr(phy_addr),
		.wr_pulse(wr_pulse),
		.rd_pulse(rd_pulse),
		.acc_dev(acc_dev),
		.acc_addr(acc_addr),
		.wr_data(wr_data),
		.rd_data(rd_data)
	);

	// Writes that land during a soft reset are dropped so the bank comes out clean.
	wire wr_ok = wr_pulse & ~chip_soft_reset; // see RQ4
	wire wr_ctrl = wr_ok & hit(acc_dev, acc_addr, DEV_MEDIUM, OFS_CTRL1); // see RQ12
	wire wr_cnt_hi = wr_ok & hit(acc_dev, acc_addr, DEV_VENDOR, OFS_GEN_CNT_HI);
	wire wr_cnt_lo = wr_ok & hit(acc_dev, acc_addr, DEV_VENDOR, OFS_GEN_CNT_LO);
	wire wr_host_lb = wr_ok & hit(acc_dev, acc_addr, DEV_VENDOR, OFS_HOST_LB);
	wire wr_pkt_begin = wr_ok & hit(acc_dev, acc_addr, DEV_VENDOR, OFS_PKT_BEGIN);
	wire rd_stat = rd_pulse & hit(acc_dev, acc_addr, DEV_MEDIUM, OFS_STAT1);
	wire wr_rst_bit = wr_data[BIT_SOFT_RESET];
	wire wr_pd_bit = wr_data[BIT_POWERDOWN];
	wire wr_lb_bit = wr_data[BIT_LOCAL_LB];
	wire srst_start = wr_ctrl & wr_rst_bit;

	// Only the named bits are ever placed; everything else stays zero.
	wire [15:0] ctrl_word = (16'(chip_soft_reset) << BIT_SOFT_RESET) // see RQ2
		| (16'(medium_soft_powerdown) << BIT_POWERDOWN)
		| (16'(medium_local_loopback_en) << BIT_LOCAL_LB); // see RQ18
	wire [15:0] stat_word = (16'(link_ll_r) << BIT_LINK_LL) // see RQ8
		| (16'h0001 << BIT_PD_ABLE); // see RQ9
	wire [15:0] fin_word = 16'(gen_fin_r) << BIT_GEN_FIN; // see RQ14

	assign rd_data =
		hit(acc_dev, acc_addr, DEV_MEDIUM, OFS_CTRL1) ? ctrl_word :
		hit(acc_dev, acc_addr, DEV_MEDIUM, OFS_STAT1) ? stat_word :
		hit(acc_dev, acc_addr, DEV_MEDIUM, OFS_DEVS_LO) ? DEVS_LO_VAL : // see RQ10
		hit(acc_dev, acc_addr, DEV_MEDIUM, OFS_DEVS_HI) ? DEVS_HI_VAL : // see RQ11
		hit(acc_dev, acc_addr, DEV_VENDOR, OFS_GEN_CNT_HI) ? gen_frame_count_high :
		hit(acc_dev, acc_addr, DEV_VENDOR, OFS_GEN_CNT_LO) ? gen_frame_count_low :
		hit(acc_dev, acc_addr, DEV_VENDOR, OFS_GEN_FIN) ? fin_word :
		hit(acc_dev, acc_addr, DEV_VENDOR, OFS_HOST_LB) ? host_side_loopback_cfg :
		hit(acc_dev, acc_addr, DEV_VENDOR, OFS_PKT_BEGIN) ? packet_begin_generation_cfg :
		16'h0000;

	// The management engine is kept out of the soft reset so the host can poll bit 15.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			chip_soft_reset <= 1'b0;
			srst_cnt_r <= 8'h00;
		end
		else if (srst_start && !chip_soft_reset)
		begin
			chip_soft_reset <= 1'b1; // see RQ1
			srst_cnt_r <= SOFT_RST_CYCLES;
		end
		else if (chip_soft_reset)
		begin
			srst_cnt_r <= srst_cnt_r - 8'h01;
			chip_soft_reset <= (srst_cnt_r != 8'h01); // see RQ2
		end
	end

	// The strap is sampled after hardware reset release and again after each soft reset.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			init_done_r <= 1'b0;
		else
			init_done_r <= ~chip_soft_reset;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			medium_soft_powerdown <= RST_CTRL1[BIT_POWERDOWN]; // see RQ6
			medium_local_loopback_en <= RST_CTRL1[BIT_LOCAL_LB];
		end
		else if (chip_soft_reset || !init_done_r)
		begin
			medium_soft_powerdown <= powerdown_strap_pin; // see RQ5
			medium_local_loopback_en <= RST_CTRL1[BIT_LOCAL_LB];
		end
		else if (wr_ctrl)
		begin
			medium_soft_powerdown <= wr_pd_bit; // see RQ3
			medium_local_loopback_en <= wr_lb_bit; // see RQ7
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gen_frame_count_high <= RST_GEN_CNT_HI;
			gen_frame_count_low <= RST_GEN_CNT_LO;
			host_side_loopback_cfg <= RST_HOST_LB;
			packet_begin_generation_cfg <= RST_PKT_BEGIN;
		end
		else if (chip_soft_reset)
		begin
			gen_frame_count_high <= RST_GEN_CNT_HI; // see RQ1
			gen_frame_count_low <= RST_GEN_CNT_LO;
			host_side_loopback_cfg <= RST_HOST_LB;
			packet_begin_generation_cfg <= RST_PKT_BEGIN;
		end
		else
		begin
			if (wr_cnt_hi)
				gen_frame_count_high <= wr_data; // see RQ17
			if (wr_cnt_lo)
				gen_frame_count_low <= wr_data; // see RQ13
			if (wr_host_lb)
				host_side_loopback_cfg <= wr_data; // see RQ15
			if (wr_pkt_begin)
				packet_begin_generation_cfg <= wr_data; // see RQ16
		end
	end

	// A read re-arms the latch with the live level, so a drop seen in that
	// same cycle still reads back as zero next time.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link_ll_r <= 1'b0;
			gen_fin_r <= RST_GEN_FIN[BIT_GEN_FIN];
		end
		else if (chip_soft_reset)
		begin
			link_ll_r <= 1'b0;
			gen_fin_r <= RST_GEN_FIN[BIT_GEN_FIN];
		end
		else
		begin
			link_ll_r <= rd_stat ? link_up : (link_ll_r & link_up); // see RQ19
			gen_fin_r <= gen_run_done;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	property p_srst_holds;
		srst_start && !chip_soft_reset |=> chip_soft_reset [*8];
	endproperty
	a_srst_holds: assert property (p_srst_holds) // see RQ1
		else $error("soft reset did not stay asserted");

	property p_srst_clears;
		$rose(chip_soft_reset) |-> ##[15:17] !chip_soft_reset;
	endproperty
	a_srst_clears: assert property (p_srst_clears) // see RQ2
		else $error("soft reset did not clear itself in time");

	property p_srst_restores;
		$fell(chip_soft_reset) |-> gen_frame_count_low == RST_GEN_CNT_LO
			&& host_side_loopback_cfg == RST_HOST_LB
			&& packet_begin_generation_cfg == RST_PKT_BEGIN;
	endproperty
	a_srst_restores: assert property (p_srst_restores) // see RQ13
		else $error("soft reset left registers not at reset values");

	property p_pd_write;
		wr_ctrl && init_done_r |=> medium_soft_powerdown == $past(wr_pd_bit);
	endproperty
	a_pd_write: assert property (p_pd_write) // see RQ3
		else $error("power-down bit did not follow the write");

	property p_lb_write;
		wr_ctrl && init_done_r |=> medium_local_loopback_en == $past(wr_lb_bit);
	endproperty
	a_lb_write: assert property (p_lb_write) // see RQ7
		else $error("loopback enable did not follow the write");

	property p_write_in_pd;
		medium_soft_powerdown && wr_host_lb |=> host_side_loopback_cfg == $past(wr_data);
	endproperty
	a_write_in_pd: assert property (p_write_in_pd) // see RQ4
		else $error("register write lost during power-down");

	property p_strap;
		$rose(init_done_r) |-> medium_soft_powerdown == $past(powerdown_strap_pin);
	endproperty
	a_strap: assert property (p_strap) // see RQ5
		else $error("power-down did not load from strap");

	property p_link_drop;
		!link_up ##1 !rd_stat |-> !link_ll_r ##1 !link_ll_r || rd_stat;
	endproperty
	a_link_drop: assert property (p_link_drop) // see RQ8
		else $error("latched link bit missed a drop");

	property p_rearm;
		rd_stat && link_up && !chip_soft_reset |=> link_ll_r;
	endproperty
	a_rearm: assert property (p_rearm) // see RQ19
		else $error("latched link bit did not re-arm on read");

	property p_fixed_words;
		stat_word[BIT_PD_ABLE] && stat_word[15:3] == 13'h0 && !stat_word[0]
			&& ctrl_word[14:12] == 3'h0 && ctrl_word[10:1] == 10'h0;
	endproperty
	a_fixed_words: assert property (p_fixed_words) // see RQ18
		else $error("fixed or reserved status bits wrong");

	property p_srst_clears_counts;
		chip_soft_reset |=> gen_frame_count_high == RST_GEN_CNT_HI
			&& gen_frame_count_low == RST_GEN_CNT_LO;
	endproperty
	a_srst_clears_counts: assert property (p_srst_clears_counts) // see RQ1
		else $error("frame count not reinitialised during soft reset");

	property p_cnt_hi_write;
		wr_cnt_hi |=> gen_frame_count_high == $past(wr_data);
	endproperty
	a_cnt_hi_write: assert property (p_cnt_hi_write) // see RQ17
		else $error("frame count high half did not take the write");

	property p_cnt_lo_write;
		wr_cnt_lo |=> gen_frame_count_low == $past(wr_data);
	endproperty
	a_cnt_lo_write: assert property (p_cnt_lo_write) // see RQ13
		else $error("frame count low half did not take the write");

	property p_pkt_write;
		wr_pkt_begin |=> packet_begin_generation_cfg == $past(wr_data);
	endproperty
	a_pkt_write: assert property (p_pkt_write) // see RQ16
		else $error("packet start setup did not take the write");

	property p_gen_fin;
		!chip_soft_reset |=> gen_fin_r == $past(gen_run_done);
	endproperty
	a_gen_fin: assert property (p_gen_fin) // see RQ14
		else $error("generator finished flag did not follow its input");

	property p_medium_only;
		wr_pulse && acc_dev != DEV_MEDIUM && init_done_r && !chip_soft_reset
			|=> $stable(medium_soft_powerdown) && $stable(medium_local_loopback_en);
	endproperty
	a_medium_only: assert property (p_medium_only) // see RQ12
		else $error("control bits changed by a write to another device");

	property p_pd_holds;
		!wr_ctrl && init_done_r && !chip_soft_reset |=> $stable(medium_soft_powerdown);
	endproperty
	a_pd_holds: assert property (p_pd_holds) // see RQ3
		else $error("power-down bit changed without a control write");
endmodule // pma_pmd_mgmt_register_bank

// ===== bench/mdio_host_model.sv
module mdio_host_model
	import pma_mgmt_pkg::*;
(
	input wire logic core_clk,
	input wire logic mdio_line,
	input wire logic [4:0] prtad,
	output logic mdc,
	output logic host_o,
	output logic host_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		mdc = 1'b0;
		host_o = 1'b1;
		host_oe_n = 1'b1;
	end

	// Eight core cycles per management clock keep each phase well above the two-cycle minimum.
	task automatic bit_cycle(input logic drive, input logic b, output logic seen);
	begin
		@(posedge core_clk);
		#1;
		mdc = 1'b0;
		host_oe_n = !drive;
		host_o = b;
		repeat (4) @(posedge core_clk);
		#1;
		seen = mdio_line;
		mdc = 1'b1;
		repeat (3) @(posedge core_clk);
	end
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] data,
		output logic [15:0] rd);
		logic [31:0] w;
		logic s;
	begin
		w = {2'b00, op, prtad, dev, 2'b10, data};
		for (int i = 0; i < 32; i++)
			bit_cycle(1'b1, 1'b1, s);
		for (int i = 31; i >= 0; i--)
		begin
			// On reads the line is released for turnaround and data.
			bit_cycle(!(op[1] && i < 18), w[i], s);
			if (i < 16)
				rd[i] = s;
		end
		@(posedge core_clk);
		#1;
		host_oe_n = 1'b1;
	end
	endtask
endmodule // mdio_host_model

// ===== bench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pma_mgmt_pkg::*;

	localparam logic [4:0] MY_PRTAD = 5'h05;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic mdc, host_o, host_oe_n, mdio_o, mdio_oe_n;
	logic powerdown_strap_pin = 1'b0;
	logic link_up = 1'b0;
	logic gen_run_done = 1'b0;
	logic chip_soft_reset, medium_soft_powerdown, medium_local_loopback_en;
	logic [15:0] gen_frame_count_high, gen_frame_count_low;
	logic [15:0] host_side_loopback_cfg, packet_begin_generation_cfg;
	int error_cnt = 0;
	int total_checks = 0;
	int soft_cnt = 0;
	int soft_len = 0;
	wire mdio_line;

	// The bus has a pull-up, so a released line reads high.
	assign mdio_line = !mdio_oe_n ? mdio_o : (!host_oe_n ? host_o : 1'b1);

	always #4 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		if (chip_soft_reset === 1'b1)
			soft_cnt++;
		else if (soft_cnt != 0)
		begin
			soft_len = soft_cnt;
			soft_cnt = 0;
		end
	end

	pma_pmd_mgmt_register_bank dut_u (
		.core_clk(core_clk), .reset_n(reset_n), .mdc(mdc), .mdio_i(mdio_line),
		.mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .phy_addr(MY_PRTAD),
		.powerdown_strap_pin(powerdown_strap_pin), .link_up(link_up),
		.gen_run_done(gen_run_done), .chip_soft_reset(chip_soft_reset),
		.medium_soft_powerdown(medium_soft_powerdown),
		.medium_local_loopback_en(medium_local_loopback_en),
		.gen_frame_count_high(gen_frame_count_high), .gen_frame_count_low(gen_frame_count_low),
		.host_side_loopback_cfg(host_side_loopback_cfg),
		.packet_begin_generation_cfg(packet_begin_generation_cfg)
	);

	mdio_host_model host_u (
		.core_clk(core_clk), .mdio_line(mdio_line), .prtad(MY_PRTAD),
		.mdc(mdc), .host_o(host_o), .host_oe_n(host_oe_n)
	);

	task automatic complete_run();
	begin
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
	begin
		total_checks++;
		if (seen !== exp)
		begin
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
			error_cnt++;
		end
	end
	endtask

	task automatic step(input int n);
	begin
		repeat (n) @(posedge core_clk);
		#1;
	end
	endtask

	task automatic wr(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] data);
		logic [15:0] d;
	begin
		host_u.frame(OP_ADDRESS, dev, addr, d);
		host_u.frame(OP_WRITE, dev, data, d);
	end
	endtask

	task automatic rd_chk(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] exp);
		logic [15:0] d;
	begin
		host_u.frame(OP_ADDRESS, dev, addr, d);
		host_u.frame(OP_READ, dev, 16'h0000, d);
		check(d, exp);
	end
	endtask

	task automatic t_reset_values();
	begin
		check(gen_frame_count_low, RST_GEN_CNT_LO);
		check(host_side_loopback_cfg, RST_HOST_LB);
		check(packet_begin_generation_cfg, RST_PKT_BEGIN);
		rd_chk(DEV_MEDIUM, OFS_CTRL1, 16'h0000);
		rd_chk(DEV_MEDIUM, OFS_STAT1, 16'h0002);
		rd_chk(DEV_MEDIUM, OFS_DEVS_LO, 16'h008B);
		rd_chk(DEV_MEDIUM, OFS_DEVS_HI, 16'hC000);
		rd_chk(DEV_VENDOR, OFS_GEN_CNT_HI, 16'h0000);
		rd_chk(DEV_VENDOR, OFS_GEN_FIN, 16'h0000);
	end
	endtask

	task automatic t_vendor_rw();
	begin
		wr(DEV_VENDOR, OFS_GEN_CNT_HI, 16'h1234);
		wr(DEV_VENDOR, OFS_GEN_CNT_LO, 16'h5678);
		wr(DEV_VENDOR, OFS_PKT_BEGIN, 16'h0F00);
		wr(DEV_VENDOR, OFS_GEN_FIN, 16'hFFFF);
		rd_chk(DEV_VENDOR, OFS_GEN_CNT_HI, 16'h1234);
		rd_chk(DEV_VENDOR, OFS_GEN_CNT_LO, 16'h5678);
		check(gen_frame_count_high, 16'h1234);
		check(gen_frame_count_low, 16'h5678);
		check(packet_begin_generation_cfg, 16'h0F00);
		rd_chk(DEV_VENDOR, OFS_GEN_FIN, 16'h0000);
		rd_chk(DEV_MEDIUM, OFS_GEN_CNT_LO, 16'h0000);
		rd_chk(5'h03, OFS_CTRL1, 16'hFFFF);
	end
	endtask

	task automatic t_control();
	begin
		wr(DEV_MEDIUM, OFS_CTRL1, 16'h7FFF);
		rd_chk(DEV_MEDIUM, OFS_CTRL1, 16'h0801);
		check({15'h0000, medium_soft_powerdown}, 16'h0001);
		check({15'h0000, medium_local_loopback_en}, 16'h0001);
		wr(DEV_VENDOR, OFS_HOST_LB, 16'h0055);
		rd_chk(DEV_VENDOR, OFS_HOST_LB, 16'h0055);
		check(host_side_loopback_cfg, 16'h0055);
		wr(DEV_MEDIUM, OFS_CTRL1, 16'h0000);
		check({medium_soft_powerdown, medium_local_loopback_en}, 16'h0000);
	end
	endtask

	task automatic t_link();
	begin
		link_up = 1'b1;
		rd_chk(DEV_MEDIUM, OFS_STAT1, 16'h0002);
		wr(DEV_MEDIUM, OFS_STAT1, 16'hFFFF);
		rd_chk(DEV_MEDIUM, OFS_STAT1, 16'h0006);
		link_up = 1'b0;
		step(10);
		link_up = 1'b1;
		rd_chk(DEV_MEDIUM, OFS_STAT1, 16'h0002);
		rd_chk(DEV_MEDIUM, OFS_STAT1, 16'h0006);
	end
	endtask

	task automatic t_gen_done();
	begin
		gen_run_done = 1'b1;
		rd_chk(DEV_VENDOR, OFS_GEN_FIN, 16'h0001);
		gen_run_done = 1'b0;
	end
	endtask

	task automatic t_soft_reset();
		int n;
	begin
		powerdown_strap_pin = 1'b1;
		wr(DEV_MEDIUM, OFS_CTRL1, 16'h8000);
		n = 0;
		while (soft_len == 0 && n < 100)
		begin
			step(1);
			n++;
		end
		if (soft_len == 0)
		begin
			error_cnt++;
			complete_run();
		end
		else
			check(16'(soft_len), 16'(SOFT_RST_CYCLES));
		rd_chk(DEV_MEDIUM, OFS_CTRL1, 16'h0800);
		rd_chk(DEV_VENDOR, OFS_GEN_CNT_HI, 16'h0000);
		check(host_side_loopback_cfg, RST_HOST_LB);
		powerdown_strap_pin = 1'b0;
	end
	endtask

	initial
	begin
		step(12);
		reset_n = 1'b1;
		step(2);
		t_reset_values();
		t_vendor_rw();
		t_control();
		t_link();
		t_gen_done();
		t_soft_reset();
		complete_run();
	end
endmodule // tb
